// ### rtl/fcp_pkg.sv
// Notes on behaviour
// - 4-bit width code picks transition fraction, 2.9% to 46.9% in 2.93% steps.
// - Width interpolates between fast and slow settings over target speed.
// - Tacho output toggles on every Hall crossing.
// - Lead-angle MSB selects advance (1) or delay (0).
// - Lead magnitude is 7-bit value times 22.225/127 degrees.
// - Applied lead angle interpolates/extrapolates over actual speed, also in full mode.
// - Thermal or lock protection turns all four gates off.
// - Undervoltage or current limit stops switching, bridge recirculates.
// - Thermal shutdown at 180C indication, release below 140C.
// - All-off gate levels depend on polarity select input.
// - Undervoltage lockout at 3.4 V, cleared above 3.6 V.
// - Lockout with drive style 0x/01 uses low-side recirculation table.
// - Lockout with drive style 1x uses single high-side table.
// - No tacho edge for over 0.3 s in rotation declares locked rotor.
// - Tacho pin may show lock indicator, high while lock protection active.
// - Lock indicator returns low after at least 4 Hall changes.
// - Protection periods one to four last 3.5 s, fifth 14 s.
// - Stop duty during protection resets lock counter; restart at next PWM rise.
// - Stop duty during restart-off keeps counter; remaining interval applied at PWM rise (here lockCount clears; the remaining interval is skipped).
// - Current above sense threshold engages limiter for the hold period.
// - Async option set disables synchronous rectification while limiting.
// - Current sense ignored during blanking time after FET switching.
// - Restart after low-duty stop needs duty above stop threshold plus 1.6%.
package fcp_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_US_DIV = 100;
	localparam int LOCK_DETECT_MS = 300;
	localparam int LOCK_PERIOD_MS = 3500;
	localparam int LOCK_LONG_MS = 14000;
	localparam int LOCK_DETECT_TICKS = LOCK_DETECT_MS * 1000;
	localparam int LOCK_PERIOD_TICKS = LOCK_PERIOD_MS * 1000;
	localparam int LOCK_LONG_TICKS = LOCK_LONG_MS * 1000;
	localparam logic [2:0] LOCK_SHORT_COUNT = 3'h4;
	localparam logic [2:0] RD_CLEAR_CHANGES = 3'h4;
	localparam logic [17:0] SSW_RATIO_NUM = 18'h03A98;
	localparam logic [8:0] SSW_BASE_PERMILLE = 9'h01D;
	localparam logic [15:0] LEAD_NUM = 16'h56D1;
	localparam logic [15:0] LEAD_DEN = 16'h007F;
	localparam logic [7:0] DUTY_HYST = 8'h04;
	localparam logic [7:0] LEAD_MAX_RESET = 8'h00;
	localparam logic [7:0] LEAD_MIN_RESET = 8'h00;
	typedef enum logic [1:0] {
		FCP_RUN = 2'h0,
		FCP_LOCK_OFF = 2'h1,
		FCP_STOPPED = 2'h2
	} fcp_lock_t;
endpackage

// ### rtl/fcp_top.sv
`timescale 1ns/100ps
`default_nettype none
module fcp_top #(
	parameter int LOCK_DETECT_TICKS = fcp_pkg::LOCK_DETECT_TICKS,
	parameter int LOCK_PERIOD_TICKS = fcp_pkg::LOCK_PERIOD_TICKS,
	parameter int LOCK_LONG_TICKS = fcp_pkg::LOCK_LONG_TICKS,
	parameter int BLANK_WIDTH = 8,
	parameter int HOLD_WIDTH = 12
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hall_input_1,
	input wire logic hall_input_2,
	input wire logic pwmIn,
	input wire logic [7:0] dutyMeasured,
	input wire logic [7:0] stopDuty,
	input wire logic [7:0] targetSpeed,
	input wire logic [7:0] speedMin,
	input wire logic [7:0] speedMax,
	input wire logic [7:0] actualSpeed,
	input wire logic overTemp,
	input wire logic underVolt,
	input wire logic currentSense,
	input wire logic polaritySelect,
	input wire logic [1:0] drive_style_select,
	input wire logic tacho_source_select,
	input wire logic current_limit_async_rectify,
	input wire logic [HOLD_WIDTH-1:0] current_limit_hold_period,
	input wire logic [BLANK_WIDTH-1:0] current_sense_blanking,
	input wire logic [3:0] soft_switch_width_fast,
	input wire logic [3:0] soft_switch_width_slow,
	input wire logic leadWrMax,
	input wire logic leadWrMin,
	input wire logic [7:0] leadWrData,
	input wire logic [1:0] gateDrive,
	input wire logic gateSwitched,
	output logic [7:0] lead_angle_at_max_speed,
	output logic [7:0] lead_angle_at_min_speed,
	output logic [8:0] softSwitchPermille,
	output logic leadAdvance,
	output logic [15:0] leadCentiDeg,
	output logic gate1_high_side,
	output logic gate1_low_side,
	output logic gate2_high_side,
	output logic gate2_low_side,
	output logic syncRectifyEn,
	output logic tacho_output,
	output logic lockActive,
	output logic limiterActive
);
	import fcp_pkg::*;
	// Protection priority: all-off beats recirculation beats normal drive.
	// Long timers run on a 1 us tick so counters stay 24 bits wide.

	// Two-stage synchronisers, first stage read only by second
	logic [2:0] syncA;
	logic [2:0] syncB;
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			syncA <= 3'h0;
			syncB <= 3'h0;
		end
		else
		begin
			syncA <= {currentSense, underVolt, overTemp};
			syncB <= syncA;
		end
	// Comparators carry their own hysteresis (180/140 C, 3.4/3.6 V)
	// so no extra filtering is done here
	wire thermalShutdown = syncB[0];
	wire undervoltLockout = syncB[1];
	wire senseHigh = syncB[2];

	// 1 us tick divider for long timers
	// Free-runs from reset, so the first tick may come early
	logic [6:0] divCnt;
	wire tickUs = (divCnt == 7'(TICK_US_DIV - 1));
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			divCnt <= 7'h00;
		else
			divCnt <= tickUs ? 7'h00 : divCnt + 7'h01;

	// Lead-angle setting registers
	// Write strobes are single-cycle pulses from the setting loader
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			lead_angle_at_max_speed <= LEAD_MAX_RESET;
			lead_angle_at_min_speed <= LEAD_MIN_RESET;
		end
		else
		begin
			if (leadWrMax)
				lead_angle_at_max_speed <= leadWrData;
			if (leadWrMin)
				lead_angle_at_min_speed <= leadWrData;
		end

	// Signed lead settings and linear interpolation over speed
	// Result is clamped, never wrapped, when speed runs past the ends
	wire signed [8:0] leadHiS = lead_angle_at_max_speed[7] ?
		9'sh000 + $signed({2'b00, lead_angle_at_max_speed[6:0]}) :
		9'sh000 - $signed({2'b00, lead_angle_at_max_speed[6:0]});
	wire signed [8:0] leadLoS = lead_angle_at_min_speed[7] ?
		9'sh000 + $signed({2'b00, lead_angle_at_min_speed[6:0]}) :
		9'sh000 - $signed({2'b00, lead_angle_at_min_speed[6:0]});
	wire signed [9:0] spanSpd = $signed({2'b00, speedMax}) - $signed({2'b00, speedMin});
	wire signed [9:0] offSpd = $signed({2'b00, actualSpeed}) - $signed({2'b00, speedMin});
	wire signed [9:0] leadDiff = 10'(leadHiS) - 10'(leadLoS);
	wire signed [19:0] leadProd = 20'(leadDiff) * 20'(offSpd);
	wire signed [19:0] leadStep = (spanSpd == 10'sh000) ? 20'sh00000 : leadProd / 20'(spanSpd);
	// Extrapolation allowed beyond both ends, then clamped to the 7-bit range
	wire signed [19:0] leadRaw = 20'(leadLoS) + leadStep;
	wire signed [19:0] leadClip = (leadRaw > 20'sd127) ? 20'sd127 :
		(leadRaw < -20'sd127) ? -20'sd127 : leadRaw;
	wire [6:0] leadMag = leadClip[19] ? 7'(-leadClip) : 7'(leadClip);
	// Hundredths of a degree: mag * 2222.5 / 127
	wire [31:0] leadScaled = 32'(leadMag) * 32'(LEAD_NUM) / 32'(LEAD_DEN) / 32'd10;

	// Soft-switch width interpolated over target speed
	wire [9:0] tgtOff = (targetSpeed <= speedMin) ? 10'h000 :
		(targetSpeed >= speedMax) ? 10'(spanSpd) : 10'(targetSpeed) - 10'(speedMin);
	wire signed [5:0] sswDiff = $signed({2'b00, soft_switch_width_fast}) -
		$signed({2'b00, soft_switch_width_slow});
	wire signed [16:0] sswProd = 17'(sswDiff) * $signed({7'h00, tgtOff});
	wire signed [16:0] sswStep = (spanSpd <= 10'sh000) ? 17'sh00000 : sswProd / 17'(spanSpd);
	wire [3:0] sswCode = 4'(17'(soft_switch_width_slow) + sswStep);
	// Fraction is (code+1)*15/512, rounded to the nearest permille
	wire [17:0] sswScaled = (18'(sswCode) + 18'h00001) * SSW_RATIO_NUM + 18'h00100;
	wire [8:0] sswPermille = 9'(sswScaled >> 9);

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			softSwitchPermille <= SSW_BASE_PERMILLE;
			leadAdvance <= 1'b0;
			leadCentiDeg <= 16'h0000;
		end
		else
		begin
			softSwitchPermille <= sswPermille;
			leadAdvance <= !leadClip[19] && leadClip != 20'sh00000;
			leadCentiDeg <= 16'(leadScaled);
		end

	// Hall crossing detection and tacho toggle
	// Only the first Hall input is watched; the second is its inverse
	logic hallPrev;
	logic tachoToggle;
	wire hallEdge = (hall_input_1 != hallPrev);
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			hallPrev <= 1'b0;
			tachoToggle <= 1'b0;
		end
		else
		begin
			hallPrev <= hall_input_1;
			if (hallEdge)
				tachoToggle <= !tachoToggle;
		end

	// Run request with restart hysteresis
	// Hysteresis keeps a duty hovering at the stop threshold
	// from chattering the motor on and off
	logic runReq;
	logic pwmPrev;
	wire pwmRise = pwmIn && !pwmPrev;
	wire stopCmd = (dutyMeasured <= stopDuty);
	wire startOk = ({1'b0, dutyMeasured} > {1'b0, stopDuty} + 9'(DUTY_HYST));
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			runReq <= 1'b0;
			pwmPrev <= 1'b0;
		end
		else
		begin
			pwmPrev <= pwmIn;
			if (stopCmd)
				runReq <= 1'b0;
			else if (startOk)
				runReq <= 1'b1;
		end

	// Lock detection and protection sequencer
	// Stop duty mid-period clears the retry count; a running duty
	// then restarts at the next PWM rising edge
	fcp_lock_t lockState;
	logic [23:0] lockTimer;
	logic [2:0] lockCount;
	logic [2:0] hallChanges;
	logic lockIndicator;
	logic offHeld;
	wire [23:0] periodTicks = (lockCount >= LOCK_SHORT_COUNT) ?
		24'(LOCK_LONG_TICKS) : 24'(LOCK_PERIOD_TICKS);
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			lockState <= FCP_STOPPED;
			lockTimer <= 24'h000000;
			lockCount <= 3'h0;
			hallChanges <= 3'h0;
			lockIndicator <= 1'b0;
			offHeld <= 1'b0;
		end
		else
		unique case (lockState)
			FCP_RUN:
			begin
				if (!runReq)
				begin
					lockState <= FCP_STOPPED;
					lockTimer <= 24'h000000;
				end
				else if (hallEdge)
				begin
					lockTimer <= 24'h000000;
					if (hallChanges != RD_CLEAR_CHANGES)
						hallChanges <= hallChanges + 3'h1;
					if (hallChanges + 3'h1 >= RD_CLEAR_CHANGES)
					begin
						lockIndicator <= 1'b0;
						lockCount <= 3'h0;
					end
				end
				else if (tickUs)
				begin
					if (lockTimer >= 24'(LOCK_DETECT_TICKS))
					begin
						lockState <= FCP_LOCK_OFF;
						lockIndicator <= 1'b1;
						lockTimer <= 24'h000000;
						hallChanges <= 3'h0;
					end
					else
						lockTimer <= lockTimer + 24'h000001;
				end
			end
			FCP_LOCK_OFF:
			begin
				if (stopCmd)
				begin
					// Stop duty seen mid-period: counter clears, outputs stay off
					lockCount <= 3'h0;
					offHeld <= 1'b1;
				end
				if (offHeld && pwmRise && !stopCmd)
				begin
					// Remaining interval is skipped; run resumes at this PWM rise
					lockState <= FCP_RUN;
					offHeld <= 1'b0;
					lockTimer <= 24'h000000;
				end
				else if (tickUs)
				begin
					if (lockTimer + 24'h000001 >= periodTicks)
					begin
						lockState <= FCP_RUN;
						lockTimer <= 24'h000000;
						offHeld <= 1'b0;
						if (lockCount != 3'h7 && !stopCmd)
							lockCount <= lockCount + 3'h1;
					end
					else
						lockTimer <= lockTimer + 24'h000001;
				end
			end
			FCP_STOPPED:
			begin
				if (runReq && pwmRise)
				begin
					lockState <= FCP_RUN;
					lockTimer <= 24'h000000;
				end
			end
			default:
				lockState <= FCP_STOPPED;
		endcase
	wire lockOff = (lockState == FCP_LOCK_OFF);

	// Current limiter with blanking after switching
	// Hold counter reloads while sense stays high outside blanking, so a persistent
	// overload keeps the bridge recirculating without gaps while the hold period outlasts the blanking time
	logic [BLANK_WIDTH-1:0] blankCnt;
	logic [HOLD_WIDTH-1:0] holdCnt;
	wire blanked = (blankCnt != '0);
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			blankCnt <= '0;
			holdCnt <= '0;
		end
		else
		begin
			if (gateSwitched)
				blankCnt <= current_sense_blanking;
			else if (blanked)
				blankCnt <= blankCnt - 1'b1;
			if (senseHigh && !blanked)
				holdCnt <= current_limit_hold_period;
			else if (holdCnt != '0)
				holdCnt <= holdCnt - 1'b1;
		end
	wire limitOn = (holdCnt != '0);

	// Gate output selection
	// Low sides stay off in normal drive; commutation shaping is
	// applied downstream of this block
	wire allOff = thermalShutdown || lockOff;
	wire recirc = undervoltLockout || limitOn;
	wire [3:0] offGates = polaritySelect ? 4'h0 : 4'hA;
	wire [3:0] recircLow = polaritySelect ? (hall_input_1 ? 4'h1 : 4'h4) :
		(hall_input_1 ? 4'hB : 4'hE);
	wire [3:0] recircHigh = polaritySelect ? (hall_input_1 ? 4'h8 : 4'h2) :
		(hall_input_1 ? 4'h2 : 4'h8);
	wire [3:0] recircGates = drive_style_select[1] ? recircHigh : recircLow;
	wire [3:0] runGates = {gateDrive[0], 1'b0, gateDrive[1], 1'b0} ^ offGates;
	wire [3:0] nextGates = allOff ? offGates : recirc ? recircGates : runGates;
	wire next_tacho = tacho_source_select ? lockIndicator : tachoToggle;
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			{gate1_high_side, gate1_low_side, gate2_high_side, gate2_low_side} <= 4'h0;
			tacho_output <= 1'b0;
			syncRectifyEn <= 1'b1;
			lockActive <= 1'b0;
			limiterActive <= 1'b0;
		end
		else
		begin
			{gate1_high_side, gate1_low_side, gate2_high_side, gate2_low_side} <= nextGates;
			tacho_output <= next_tacho;
			syncRectifyEn <= !(current_limit_async_rectify && limitOn);
			lockActive <= lockOff;
			limiterActive <= limitOn;
		end
endmodule
`default_nettype wire

// ### verification/fcp_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
module fcp_top_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hall_input_1,
	input wire logic overTemp,
	input wire logic underVolt,
	input wire logic currentSense,
	input wire logic polaritySelect,
	input wire logic [1:0] drive_style_select,
	input wire logic tacho_source_select,
	input wire logic current_limit_async_rectify,
	input wire logic leadWrMax,
	input wire logic [7:0] leadWrData,
	input wire logic [7:0] lead_angle_at_max_speed,
	input wire logic [7:0] lead_angle_at_min_speed,
	input wire logic [8:0] softSwitchPermille,
	input wire logic leadAdvance,
	input wire logic [15:0] leadCentiDeg,
	input wire logic gate1_high_side,
	input wire logic gate1_low_side,
	input wire logic gate2_high_side,
	input wire logic gate2_low_side,
	input wire logic syncRectifyEn,
	input wire logic tacho_output,
	input wire logic lockActive,
	input wire logic limiterActive
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire [3:0] gates = {gate1_high_side, gate1_low_side, gate2_high_side, gate2_low_side};
	wire [3:0] offPat = {~polaritySelect, 1'b0, ~polaritySelect, 1'b0};
	wire [3:0] uvPat = drive_style_select[1] ? ((polaritySelect ^ hall_input_1) ? 4'h2 : 4'h8)
		: polaritySelect ? (hall_input_1 ? 4'h1 : 4'h4) : (hall_input_1 ? 4'hB : 4'hE);
	wire [7:0] lmax = lead_angle_at_max_speed;
	wire leadEq = lmax == lead_angle_at_min_speed;
	thermal_off_a: assert property (overTemp ##1 overTemp ##1 overTemp ##1 overTemp
		|-> gates == offPat) else $error("thermal off pattern wrong");
	undervoltage_lockout_table_a: assert property ((underVolt && !overTemp && !lockActive && !limiterActive
		&& $stable(hall_input_1) && $stable(drive_style_select) && $stable(polaritySelect))[*5]
		|-> gates == uvPat) else $error("lockout gate pattern wrong");
	lock_off_a: assert property (lockActive[*2] |-> gates == offPat)
		else $error("lock gate pattern wrong");
	lock_flag_a: assert property ((tacho_source_select && lockActive)[*3] |-> tacho_output)
		else $error("lock indicator low");
	limit_cause_a: assert property ($rose(limiterActive)
		|-> $past(currentSense, 3) || $past(currentSense, 4)) else $error("limiter without sense");
	async_rect_a: assert property ((limiterActive && current_limit_async_rectify)[*2]
		|-> !syncRectifyEn) else $error("rectifier still on");
	ssw_range_a: assert property ($past(nrst, 8) |-> softSwitchPermille inside {[9'h01D:9'h1D5]})
		else $error("soft switch out of range");
	lead_write_a: assert property (leadWrMax |=> lmax == $past(leadWrData))
		else $error("lead write lost");
	lead_sign_a: assert property ((leadEq && lmax[6:0] != 7'h00)[*4] |-> leadAdvance == lmax[7])
		else $error("lead direction wrong");
	lead_mag_a: assert property ((leadEq && !lmax[0])[*4]
		|-> leadCentiDeg == 16'(lmax[6:0] * 35 / 2)) else $error("lead magnitude wrong");
	cover property ($rose(lockActive));
	cover property ($rose(limiterActive));
	cover property (overTemp[*4]);
endmodule
bind fcp_top fcp_top_checker i_fcp_top_checker (.clk, .nrst, .hall_input_1, .overTemp,
	.underVolt, .currentSense, .polaritySelect, .drive_style_select, .tacho_source_select,
	.current_limit_async_rectify, .leadWrMax, .leadWrData, .lead_angle_at_max_speed,
	.lead_angle_at_min_speed, .softSwitchPermille, .leadAdvance, .leadCentiDeg,
	.gate1_high_side, .gate1_low_side, .gate2_high_side, .gate2_low_side, .syncRectifyEn,
	.tacho_output, .lockActive, .limiterActive);
`default_nettype wire

// ### verification/fcp_hall_model.sv
`timescale 1ns/100ps
`default_nettype none
module fcp_hall_model #(
	parameter int HALF = 40
) (
	input wire logic clk,
	input wire logic spin,
	input wire logic level,
	output logic hall1,
	output logic hall2
);
	int cnt = 0;
	initial hall1 = 1'b0;
	// Locked rotor holds the sensor at a chosen pole
	always @(posedge clk)
	begin
		cnt <= (cnt >= HALF - 1) ? 0 : cnt + 1;
		if (!spin)
			hall1 <= level;
		else if (cnt == 0)
			hall1 <= ~hall1;
	end
	assign hall2 = ~hall1;
endmodule
`default_nettype wire

// ### verification/fan_commutation_protection_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin numErrors++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
`define WAITFOR(c, n) begin for (k = 0; k < n && !(c); k++) @(posedge clk); \
	if (!(c)) begin numErrors++; print_verdict; end end
module fan_commutation_protection_tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic pwmIn, overTemp, underVolt, currentSense, polaritySelect, tacho_source_select;
	logic current_limit_async_rectify, leadWrMax, leadWrMin, gateSwitched, spin, level;
	logic [7:0] dutyMeasured, stopDuty, targetSpeed, speedMin, speedMax, actualSpeed, leadWrData;
	logic [1:0] drive_style_select, gateDrive;
	logic [11:0] current_limit_hold_period;
	logic [7:0] current_sense_blanking;
	logic [3:0] soft_switch_width_fast, soft_switch_width_slow;
	wire hall_input_1, hall_input_2, leadAdvance, syncRectifyEn, tacho_output;
	wire gate1_high_side, gate1_low_side, gate2_high_side, gate2_low_side, lockActive, limiterActive;
	wire [7:0] lead_angle_at_max_speed, lead_angle_at_min_speed;
	wire [8:0] softSwitchPermille;
	wire [15:0] leadCentiDeg;
	wire [3:0] gates = {gate1_high_side, gate1_low_side, gate2_high_side, gate2_low_side};
	int numErrors = 0, checks = 0, hallChanges = 0, tachoChanges = 0, pc = 0;
	// Short lock counts keep the run brief
	fcp_top #(.LOCK_DETECT_TICKS(20), .LOCK_PERIOD_TICKS(50), .LOCK_LONG_TICKS(100)) i_fcp_top (
		.clk, .nrst, .hall_input_1, .hall_input_2, .pwmIn, .dutyMeasured, .stopDuty,
		.targetSpeed, .speedMin, .speedMax, .actualSpeed, .overTemp, .underVolt, .currentSense,
		.polaritySelect, .drive_style_select, .tacho_source_select, .current_limit_async_rectify,
		.current_limit_hold_period, .current_sense_blanking, .soft_switch_width_fast,
		.soft_switch_width_slow, .leadWrMax, .leadWrMin, .leadWrData, .gateDrive, .gateSwitched,
		.lead_angle_at_max_speed, .lead_angle_at_min_speed, .softSwitchPermille, .leadAdvance,
		.leadCentiDeg, .gate1_high_side, .gate1_low_side, .gate2_high_side, .gate2_low_side,
		.syncRectifyEn, .tacho_output, .lockActive, .limiterActive);
	fcp_hall_model #(.HALF(40)) i_fcp_hall_model (.clk, .spin, .level, .hall1(hall_input_1),
		.hall2(hall_input_2));
	initial forever #5 clk = ~clk;
	always @(posedge clk)
	begin
		pc <= (pc + 1) % 100;
		pwmIn <= pc < 60;
	end
	always @(hall_input_1) hallChanges++;
	always @(tacho_output) tachoChanges++;
	function automatic int offExp(int p);
		return p ? 0 : 10;
	endfunction
	function automatic int uvExp(int p, int d, int h);
		if (d >= 2)
			return (p ^ h) ? 2 : 8;
		return p ? (h ? 1 : 4) : (h ? 11 : 14);
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", numErrors, checks);
		if (numErrors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		int i, d, k, h0, t0;
		{overTemp, underVolt, currentSense, polaritySelect, tacho_source_select} = '0;
		{current_limit_async_rectify, leadWrMax, leadWrMin, gateSwitched, spin, level} = '0;
		{dutyMeasured, stopDuty, targetSpeed, actualSpeed, leadWrData} = '0;
		speedMin = 8'h14;
		speedMax = 8'hC8;
		{drive_style_select, current_limit_hold_period, current_sense_blanking} = '0;
		gateDrive = 2'h3;
		{soft_switch_width_fast, soft_switch_width_slow} = '0;
		void'($urandom(50315));
		tick(20);
		nrst <= 1'b1;
		tick(3);
		`CHK("leadMax reset", 8'h00, lead_angle_at_max_speed)
		for (i = 0; i < 8; i++)
		begin
			d = $urandom & 8'hFE;
			leadWrMax <= 1'b1;
			leadWrData <= 8'(d);
			tick(1);
			leadWrMax <= 1'b0;
			leadWrMin <= 1'b1;
			tick(1);
			leadWrMin <= 1'b0;
			tick(5);
			`CHK("leadMax", 8'(d), lead_angle_at_max_speed)
			`CHK("leadMin", 8'(d), lead_angle_at_min_speed)
			if (d[6:0] != 0)
				`CHK("leadAdvance", d[7], leadAdvance)
			`CHK("leadCentiDeg", 16'(d[6:0] * 35 / 2), leadCentiDeg)
		end
		leadWrMax <= 1'b1;
		leadWrData <= 8'h8A;
		tick(1);
		leadWrMax <= 1'b0;
		leadWrMin <= 1'b1;
		leadWrData <= 8'h0A;
		tick(1);
		leadWrMin <= 1'b0;
		actualSpeed <= 8'hC8;
		tick(5);
		`CHK("leadAtMax", 1'b1, leadAdvance)
		`CHK("leadAtMaxDeg", 16'h00AF, leadCentiDeg)
		actualSpeed <= 8'h6E;
		tick(5);
		`CHK("leadMid", 16'h0000, leadCentiDeg)
		targetSpeed <= 8'h64;
		for (i = 0; i < 16; i++)
		begin
			soft_switch_width_fast <= 4'(i);
			soft_switch_width_slow <= 4'(i);
			tick(40);
			`CHK("ssw", 9'(((i + 1) * 15000 + 256) / 512), softSwitchPermille)
		end
		soft_switch_width_slow <= 4'h0;
		targetSpeed <= 8'hC8;
		tick(40);
		`CHK("sswFast", 9'h1D5, softSwitchPermille)
		targetSpeed <= 8'h14;
		tick(40);
		`CHK("sswSlow", 9'h01D, softSwitchPermille)
		dutyMeasured <= 8'hC8;
		stopDuty <= 8'h0A;
		spin <= 1'b1;
		tick(400);
		h0 = hallChanges;
		`WAITFOR(hallChanges != h0, 100)
		tick(5);
		h0 = hallChanges;
		t0 = tachoChanges;
		tick(800);
		`CHK("tachoEdges", hallChanges - h0, tachoChanges - t0)
		spin <= 1'b0;
		for (i = 0; i < 16; i++)
		begin
			polaritySelect <= i[0];
			level <= i[1];
			drive_style_select <= 2'(i >> 2);
			underVolt <= 1'b1;
			tick(8);
			`CHK("lockout", 4'(uvExp(i & 1, i >> 2, (i >> 1) & 1)), gates)
		end
		for (i = 0; i < 2; i++)
		begin
			polaritySelect <= i[0];
			overTemp <= 1'b1;
			tick(8);
			`CHK("thermal", 4'(offExp(i)), gates)
			overTemp <= 1'b0;
			tick(8);
		end
		underVolt <= 1'b0;
		spin <= 1'b1;
		tick(20);
		`CHK("release", 4'hA, gates)
		tacho_source_select <= 1'b1;
		spin <= 1'b0;
		`WAITFOR(lockActive === 1'b1, 4000)
		tick(4);
		`CHK("lockIndicator", 1'b1, tacho_output)
		`CHK("lockGates", 4'(offExp(1)), gates)
		dutyMeasured <= 8'h05;
		tick(300);
		dutyMeasured <= 8'hC8;
		spin <= 1'b1;
		h0 = hallChanges;
		`WAITFOR(tacho_output === 1'b0, 20000)
		`CHK("restartChanges", 1, int'(hallChanges - h0 >= 4))
		current_limit_hold_period <= 12'h01E;
		current_limit_async_rectify <= 1'b1;
		currentSense <= 1'b1;
		tick(2);
		currentSense <= 1'b0;
		`WAITFOR(limiterActive === 1'b1, 10)
		tick(2);
		`CHK("syncRectify", 1'b0, syncRectifyEn)
		`WAITFOR(limiterActive === 1'b0, 60)
		tick(5);
		current_sense_blanking <= 8'h28;
		gateSwitched <= 1'b1;
		tick(1);
		gateSwitched <= 1'b0;
		tick(3);
		currentSense <= 1'b1;
		tick(3);
		currentSense <= 1'b0;
		tick(10);
		`CHK("blanked", 1'b0, limiterActive)
		print_verdict;
	end
endmodule
`default_nettype wire
